// file: rtl/dmss_defs.vh
`ifndef DMSS_DEFS_VH
`define DMSS_DEFS_VH
// ****************************************************
// Object indices
// ****************************************************
`define DMSS_IDX_MODE_SEL   16'h6060
`define DMSS_IDX_MODE_DISP  16'h6061
`define DMSS_IDX_POLARITY   16'h607e
`define DMSS_IDX_ENC_RES    16'h608f
`define DMSS_IDX_GEAR       16'h6091
`define DMSS_IDX_FEED       16'h6092
`define DMSS_IDX_FACTOR     16'h6093
// ****************************************************
// Mode codes
// ****************************************************
`define DMSS_MODE_OFF       8'h00
`define DMSS_MODE_PP        8'h01
`define DMSS_MODE_PV        8'h03
`define DMSS_MODE_HOME      8'h06
`define DMSS_MODE_CSP       8'h08
// ****************************************************
// Reset values and fixed entries
// ****************************************************
`define DMSS_MODE_RST       8'h01
`define DMSS_POL_RST        8'h00
`define DMSS_ONE_RST        32'h00000001
`define DMSS_NUM_ENTRIES    32'h00000002
`define DMSS_ENC_REV        32'h00000001
// Numerator must stay below 2 x 10^9
`define DMSS_NUM_LIMIT      96'h000000000000000077359400
// ****************************************************
// Abort and emergency codes
// ****************************************************
`define DMSS_ABT_OVF        32'h06040047
`define DMSS_ABT_RO         32'h06010002
`define DMSS_ABT_NOOBJ      32'h06020000
`define DMSS_ABT_NOSUB      32'h06090011
`define DMSS_ABT_RANGE      32'h06090030
`define DMSS_EMCY_OVF       16'hff01
`define DMSS_EMCY_CLR       16'h0000
// ****************************************************
// Bit positions and counts
// ****************************************************
`define DMSS_ERRB_OVF       11
`define DMSS_POLB_POS       7
`define DMSS_POLB_VEL       6
`define DMSS_CWB_HOME       4
`define DMSS_DIV_LAST       6'h3f
`endif

// file: rtl/dmss_top.v
`timescale 1ns/10ps
`include "dmss_defs.vh"

module dmss_top #(
    parameter [31:0] ENC_INC_DEFAULT = 32'h00000bb8, // Encoder increments
    parameter [31:0] FEED_DEFAULT    = 32'h00000bb8  // Feed at delivery
) (
    input  wire        SYS_CLK,        // System clock
    input  wire        NRST,           // Sync reset, active low
    input  wire        OD_REQ,         // Object access request pulse
    input  wire        OD_WR,          // 1 write, 0 read
    input  wire [15:0] OD_INDEX,       // Object index
    input  wire [7:0]  OD_SUB,         // Subindex
    input  wire [31:0] OD_WDATA,       // Write data
    output reg         OD_DONE,        // Answer pulse
    output reg  [31:0] OD_RDATA,       // Read data
    output reg         OD_ABORT,       // Access refused
    output reg  [31:0] OD_ABORT_CODE,  // Abort code
    input  wire [15:0] CTRL_WORD,      // Command word
    input  wire        SETPOINT_STB,   // New set-point received
    input  wire        ENC_LOAD,       // Encoder settings changed
    input  wire [31:0] ENC_INCREMENTS, // New increments per revolution
    output reg         ENC_ABORT,      // Encoder change refused
    input  wire [31:0] POS_INTERNAL,   // Position in increments
    output reg  [31:0] POS_ACTUAL,     // Position in user units
    output reg         POS_VALID,      // New user position pulse
    input  wire [31:0] VEL_IN,         // Speed value
    output reg  [31:0] VEL_OUT,        // Speed with polarity
    output reg  [7:0]  MODE_ACTIVE,    // Active mode
    output reg  [15:0] ERR_REG,        // Vendor error register
    output reg         EMCY_STB,       // Emergency message pulse
    output reg  [15:0] EMCY_CODE,      // Emergency code
    output reg         LIMIT_RESCALE,  // Rescale stored limits pulse
    output reg         LIMIT_NEG       // Negative position polarity
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;
    localparam [1:0] PD_NONE = 2'h0;
    localparam [1:0] PD_SETP = 2'h1;
    localparam [1:0] PD_HOME = 2'h2;

    reg  [7:0]  mode_sel_r;
    reg  [1:0]  pend_r;
    reg         cw_home_q_r;
    reg  [7:0]  pol_r;
    reg  [31:0] enc_inc_r;
    reg  [31:0] gmot_r;
    reg  [31:0] gshf_r;
    reg  [31:0] feed_r;
    reg  [31:0] fshf_r;
    reg  [31:0] fnum_r;
    reg  [31:0] fden_r;
    reg  [1:0]  st_r;
    reg  [63:0] dvd_r;
    reg  [31:0] rem_r;
    reg  [5:0]  cnt_r;
    reg         neg_r;

    reg  [31:0] rd_val;
    reg         hit;
    reg         ro;
    reg         nosub;
    reg  [31:0] c_enc;
    reg  [31:0] c_gm;
    reg  [31:0] c_gs;
    reg  [31:0] c_fd;
    reg  [31:0] c_fs;
    reg         scl_wr;

    wire        wr       = OD_REQ & OD_WR;
    wire [95:0] cand_num = c_enc * c_gm * c_fs;
    wire [63:0] cand_den = c_fd * c_gs;
    wire        cand_ovf = (cand_num >= `DMSS_NUM_LIMIT) |
                           (cand_den[63:32] != 32'h00000000) |
                           (cand_num == 96'h0) | (cand_den == 64'h0);
    wire [32:0] rem_sh   = {rem_r, dvd_r[63]};
    wire        rem_ge   = rem_sh >= {1'b0, fnum_r};
    wire [32:0] rem_sub  = rem_sh - {1'b0, fnum_r};
    wire [31:0] pos_mag  = POS_INTERNAL[31] ? (32'h0 - POS_INTERNAL)
                                            : POS_INTERNAL;
    wire [31:0] quo      = dvd_r[31:0];
    wire        conv_ovf = dvd_r[63:31] != 33'h0;
    wire        home_edge = CTRL_WORD[`DMSS_CWB_HOME] & ~cw_home_q_r;

    // Valid operating mode codes
    function mode_ok;
        input [31:0] v;
        begin
            case (v)
                32'h00000000, 32'h00000001, 32'h00000003,
                32'h00000006, 32'h00000008: mode_ok = 1'b1;
                default:                    mode_ok = 1'b0;
            endcase
        end
    endfunction

    // ****************************************************
    // Object decode and read data
    // ****************************************************
    always @* begin
        rd_val = 32'h0;
        hit    = 1'b1;
        ro     = 1'b1;
        nosub  = 1'b0;
        case (OD_INDEX)
            `DMSS_IDX_MODE_SEL: begin
                rd_val = {24'h0, mode_sel_r};
                ro     = 1'b0;
                nosub  = OD_SUB != 8'h00;
            end
            `DMSS_IDX_MODE_DISP: begin
                rd_val = {24'h0, MODE_ACTIVE};
                nosub  = OD_SUB != 8'h00;
            end
            `DMSS_IDX_POLARITY: begin
                rd_val = {24'h0, pol_r};
                ro     = 1'b0;
                nosub  = OD_SUB != 8'h00;
            end
            `DMSS_IDX_ENC_RES, `DMSS_IDX_GEAR,
            `DMSS_IDX_FEED, `DMSS_IDX_FACTOR: begin
                case (OD_SUB)
                    8'h00: rd_val = `DMSS_NUM_ENTRIES;
                    8'h01: begin
                        case (OD_INDEX)
                            `DMSS_IDX_ENC_RES: rd_val = enc_inc_r;
                            `DMSS_IDX_GEAR:    rd_val = gmot_r;
                            `DMSS_IDX_FEED:    rd_val = feed_r;
                            default:           rd_val = fnum_r;
                        endcase
                        ro = (OD_INDEX == `DMSS_IDX_ENC_RES) |
                             (OD_INDEX == `DMSS_IDX_FACTOR);
                    end
                    8'h02: begin
                        case (OD_INDEX)
                            `DMSS_IDX_ENC_RES: rd_val = `DMSS_ENC_REV;
                            `DMSS_IDX_GEAR:    rd_val = gshf_r;
                            `DMSS_IDX_FEED:    rd_val = fshf_r;
                            default:           rd_val = fden_r;
                        endcase
                        ro = (OD_INDEX == `DMSS_IDX_ENC_RES) |
                             (OD_INDEX == `DMSS_IDX_FACTOR);
                    end
                    default: nosub = 1'b1;
                endcase
            end
            default: hit = 1'b0;
        endcase
    end

    // ****************************************************
    // Candidate scaling values for the overflow check
    // ****************************************************
    always @* begin
        c_enc  = ENC_LOAD ? ENC_INCREMENTS : enc_inc_r;
        c_gm   = gmot_r;
        c_gs   = gshf_r;
        c_fd   = feed_r;
        c_fs   = fshf_r;
        scl_wr = 1'b0;
        if (wr & hit & ~nosub & ~ro) begin
            case (OD_INDEX)
                `DMSS_IDX_GEAR: begin
                    scl_wr = 1'b1;
                    if (OD_SUB == 8'h01)
                        c_gm = OD_WDATA;
                    else
                        c_gs = OD_WDATA;
                end
                `DMSS_IDX_FEED: begin
                    scl_wr = 1'b1;
                    if (OD_SUB == 8'h01)
                        c_fd = OD_WDATA;
                    else
                        c_fs = OD_WDATA;
                end
                default: scl_wr = 1'b0;
            endcase
        end
    end

    // ****************************************************
    // Object access, configuration and mode activation
    // ****************************************************
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            OD_DONE       <= 1'b0;
            OD_RDATA      <= 32'h0;
            OD_ABORT      <= 1'b0;
            OD_ABORT_CODE <= 32'h0;
            ENC_ABORT     <= 1'b0;
            mode_sel_r    <= `DMSS_MODE_RST;
            MODE_ACTIVE   <= `DMSS_MODE_RST;
            pend_r        <= PD_NONE;
            cw_home_q_r   <= 1'b0;
            pol_r         <= `DMSS_POL_RST;
            LIMIT_NEG     <= 1'b0;
            LIMIT_RESCALE <= 1'b0;
            enc_inc_r     <= ENC_INC_DEFAULT;
            gmot_r        <= `DMSS_ONE_RST;
            gshf_r        <= `DMSS_ONE_RST;
            feed_r        <= FEED_DEFAULT;
            fshf_r        <= `DMSS_ONE_RST;
            fnum_r        <= `DMSS_ONE_RST;
            fden_r        <= `DMSS_ONE_RST;
            VEL_OUT       <= 32'h0;
        end else begin
            OD_DONE       <= OD_REQ;
            OD_ABORT      <= 1'b0;
            OD_RDATA      <= 32'h0;
            ENC_ABORT     <= 1'b0;
            LIMIT_RESCALE <= 1'b0;
            cw_home_q_r   <= CTRL_WORD[`DMSS_CWB_HOME];
            LIMIT_NEG     <= pol_r[`DMSS_POLB_POS];
            // Speed polarity
            VEL_OUT <= pol_r[`DMSS_POLB_VEL] ? (32'h0 - VEL_IN)
                                             : VEL_IN;
            // Deferred mode start
            if (pend_r == PD_SETP && SETPOINT_STB) begin
                MODE_ACTIVE <= mode_sel_r;
                pend_r      <= PD_NONE;
            end
            if (pend_r == PD_HOME && home_edge) begin
                MODE_ACTIVE <= mode_sel_r;
                pend_r      <= PD_NONE;
            end
            // Scaling recompute, refused on overflow
            if ((ENC_LOAD | scl_wr) & ~cand_ovf) begin
                enc_inc_r     <= c_enc;
                gmot_r        <= c_gm;
                gshf_r        <= c_gs;
                feed_r        <= c_fd;
                fshf_r        <= c_fs;
                fnum_r        <= cand_num[31:0];
                fden_r        <= cand_den[31:0];
                LIMIT_RESCALE <= 1'b1;
            end
            if (ENC_LOAD & cand_ovf)
                ENC_ABORT <= 1'b1;
            if (OD_REQ) begin
                if (!hit) begin
                    OD_ABORT      <= 1'b1;
                    OD_ABORT_CODE <= `DMSS_ABT_NOOBJ;
                end else if (nosub) begin
                    OD_ABORT      <= 1'b1;
                    OD_ABORT_CODE <= `DMSS_ABT_NOSUB;
                end else if (!OD_WR) begin
                    OD_RDATA      <= rd_val;
                end else if (ro) begin
                    OD_ABORT      <= 1'b1;
                    OD_ABORT_CODE <= `DMSS_ABT_RO;
                end else if (scl_wr & cand_ovf) begin
                    OD_ABORT      <= 1'b1;
                    OD_ABORT_CODE <= `DMSS_ABT_OVF;
                end else if (OD_INDEX == `DMSS_IDX_POLARITY) begin
                    pol_r         <= OD_WDATA[7:0];
                    LIMIT_RESCALE <= 1'b1;
                end else if (OD_INDEX == `DMSS_IDX_MODE_SEL) begin
                    if (!mode_ok(OD_WDATA)) begin
                        OD_ABORT      <= 1'b1;
                        OD_ABORT_CODE <= `DMSS_ABT_RANGE;
                    end else begin
                        mode_sel_r <= OD_WDATA[7:0];
                        case (OD_WDATA[7:0])
                            `DMSS_MODE_PP, `DMSS_MODE_PV:
                                pend_r <= PD_SETP;
                            `DMSS_MODE_HOME:
                                pend_r <= PD_HOME;
                            default: begin
                                pend_r      <= PD_NONE;
                                MODE_ACTIVE <= OD_WDATA[7:0];
                            end
                        endcase
                    end
                end
            end
        end
    end

    // ****************************************************
    // Position conversion: increments * divisor / numerator
    // ****************************************************
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            st_r       <= ST_IDLE;
            dvd_r      <= 64'h0;
            rem_r      <= 32'h0;
            cnt_r      <= 6'h0;
            neg_r      <= 1'b0;
            POS_ACTUAL <= 32'h0;
            POS_VALID  <= 1'b0;
            ERR_REG    <= 16'h0;
            EMCY_STB   <= 1'b0;
            EMCY_CODE  <= 16'h0;
        end else begin
            POS_VALID <= 1'b0;
            EMCY_STB  <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    // Magnitude times divisor, sign kept aside
                    dvd_r <= pos_mag * fden_r;
                    neg_r <= POS_INTERNAL[31];
                    rem_r <= 32'h0;
                    cnt_r <= 6'h0;
                    st_r  <= ST_RUN;
                end
                ST_RUN: begin
                    // One restoring step per cycle
                    rem_r <= rem_ge ? rem_sub[31:0] : rem_sh[31:0];
                    dvd_r <= {dvd_r[62:0], rem_ge};
                    cnt_r <= cnt_r + 6'h1;
                    if (cnt_r == `DMSS_DIV_LAST)
                        st_r <= ST_DONE;
                end
                ST_DONE: begin
                    st_r <= ST_IDLE;
                    if (!conv_ovf) begin
                        POS_VALID  <= 1'b1;
                        POS_ACTUAL <= (neg_r ^ pol_r[`DMSS_POLB_POS])
                                      ? (32'h0 - quo) : quo;
                    end
                    if (conv_ovf & ~ERR_REG[`DMSS_ERRB_OVF]) begin
                        ERR_REG[`DMSS_ERRB_OVF] <= 1'b1;
                        EMCY_STB  <= 1'b1;
                        EMCY_CODE <= `DMSS_EMCY_OVF;
                    end
                    if (~conv_ovf & ERR_REG[`DMSS_ERRB_OVF]) begin
                        ERR_REG[`DMSS_ERRB_OVF] <= 1'b0;
                        EMCY_STB  <= 1'b1;
                        EMCY_CODE <= `DMSS_EMCY_CLR;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

endmodule

// file: tb/dmss_checker.sv
`timescale 1ns/10ps
`include "dmss_defs.vh"
// ****************************************
// Port checks for mode and scaling
// ****************************************
module dmss_checker (
    input wire        SYS_CLK,       // Clock
    input wire        NRST,          // Sync reset
    input wire        OD_REQ,        // Request
    input wire        OD_WR,         // Write
    input wire [15:0] OD_INDEX,      // Index
    input wire [7:0]  OD_SUB,        // Subindex
    input wire [31:0] OD_WDATA,      // Write data
    input wire        OD_DONE,       // Answer
    input wire        OD_ABORT,      // Refused
    input wire [31:0] OD_ABORT_CODE, // Abort code
    input wire [15:0] CTRL_WORD,     // Command word
    input wire        SETPOINT_STB,  // Set-point
    input wire [7:0]  MODE_ACTIVE,   // Active mode
    input wire [15:0] ERR_REG,       // Error register
    input wire        EMCY_STB,      // Emergency
    input wire [15:0] EMCY_CODE,     // Emergency code
    input wire        LIMIT_NEG      // Negative polarity
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);
    // Decoded requests and homing edge
    reg  ctl4_r;
    wire wr_hit  = OD_REQ && OD_WR;
    wire mode_ok = OD_WDATA inside {32'h0, 32'h1, 32'h3, 32'h6, 32'h8};
    wire ro_hit  = wr_hit && OD_SUB == 8'h01 &&
                   (OD_INDEX == `DMSS_IDX_ENC_RES ||
                    OD_INDEX == `DMSS_IDX_FACTOR);
    wire home_edge = CTRL_WORD[4] && !ctl4_r;
    always @(posedge SYS_CLK) begin
        ctl4_r <= CTRL_WORD[4];
    end
    sequence s_mode_wr;
        wr_hit && OD_INDEX == `DMSS_IDX_MODE_SEL && OD_SUB == 8'h00;
    endsequence
    sequence s_pol_wr;
        wr_hit && OD_INDEX == `DMSS_IDX_POLARITY && OD_SUB == 8'h00;
    endsequence
    a_answer_next: assert property (OD_REQ |=> OD_DONE)
        else $error("answer missing");
    a_mode_code: assert property (s_mode_wr ##0 !mode_ok |=>
        OD_ABORT && OD_ABORT_CODE == `DMSS_ABT_RANGE)
        else $error("bad mode taken");
    a_mode_direct: assert property (s_mode_wr ##0
        (OD_WDATA == 32'h0 || OD_WDATA == 32'h8) |=>
        MODE_ACTIVE == $past(OD_WDATA[7:0])) else $error("mode not applied");
    a_ro_refused: assert property (ro_hit |=> OD_ABORT &&
        OD_ABORT_CODE == `DMSS_ABT_RO) else $error("read-only written");
    a_zero_refused: assert property (wr_hit && OD_SUB == 8'h01 &&
        OD_INDEX == `DMSS_IDX_GEAR && OD_WDATA == 32'h0 |=> OD_ABORT &&
        OD_ABORT_CODE == `DMSS_ABT_OVF) else $error("zero gear taken");
    a_pp_start: assert property ($past(NRST) &&
        $changed(MODE_ACTIVE) &&
        (MODE_ACTIVE == 8'h01 || MODE_ACTIVE == 8'h03) |->
        $past(SETPOINT_STB) || $past(SETPOINT_STB, 2))
        else $error("profile mode without set-point");
    a_home_start: assert property ($past(NRST) &&
        $changed(MODE_ACTIVE) && MODE_ACTIVE == 8'h06 |->
        $past(home_edge) || $past(home_edge, 2))
        else $error("homing without edge");
    a_ovf_set: assert property ($past(NRST) && $rose(ERR_REG[11]) |->
        EMCY_STB && EMCY_CODE == `DMSS_EMCY_OVF)
        else $error("overflow not sent");
    a_ovf_clear: assert property ($past(NRST) &&
        $fell(ERR_REG[11]) |-> EMCY_STB && EMCY_CODE == `DMSS_EMCY_CLR)
        else $error("clear not sent");
    a_neg_follow: assert property (s_pol_wr |-> ##2
        LIMIT_NEG == $past(OD_WDATA[7], 2)) else $error("polarity lost");
endmodule
bind dmss_top dmss_checker u_chk (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .OD_REQ(OD_REQ), .OD_WR(OD_WR),
    .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB), .OD_WDATA(OD_WDATA),
    .OD_DONE(OD_DONE), .OD_ABORT(OD_ABORT), .OD_ABORT_CODE(OD_ABORT_CODE),
    .CTRL_WORD(CTRL_WORD), .SETPOINT_STB(SETPOINT_STB),
    .MODE_ACTIVE(MODE_ACTIVE), .ERR_REG(ERR_REG), .EMCY_STB(EMCY_STB),
    .EMCY_CODE(EMCY_CODE), .LIMIT_NEG(LIMIT_NEG)
);

// file: tb/dmss_host.sv
`timescale 1ns/10ps
// ****************************************
// Configuring host on the object port
// ****************************************
module dmss_host (
    input  wire        clk,      // System clock
    output reg         od_req,   // Request pulse
    output reg         od_wr,    // Write select
    output reg  [15:0] od_index, // Object index
    output reg  [7:0]  od_sub,   // Subindex
    output reg  [31:0] od_wdata  // Write data
);
    reg [64:0] exp_q[$]; // Expected {abort, code, rdata}
    // Idle port state
    initial begin
        od_req = 1'b0;
        od_wr = 1'b0;
        od_index = 16'h0;
        od_sub = 8'h0;
        od_wdata = 32'h0;
    end
    // One access; scaling kept below the ceiling unless a refusal is
    // wanted, set before other traffic
    task access(input bit w, input [15:0] i, input [7:0] s,
                input [31:0] d, input bit ab, input [31:0] c, input [31:0] r);
        @(negedge clk);
        od_req = 1'b1;
        od_wr = w;
        od_index = i;
        od_sub = s;
        od_wdata = d;
        exp_q.push_back({ab, c, r});
        @(posedge clk);
        od_req <= 1'b0;
        od_wr <= ~w;
        od_index <= ~i;
        od_sub <= ~s;
        od_wdata <= ~d;
    endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/10ps
`include "dmss_defs.vh"
`define CHK(a, e) begin \
    tests_run++; \
    if ((a) !== (e)) begin \
        n_mismatch++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
end
module testbench;
    localparam [31:0] ENC = 32'h00000bb8;
    reg         sys_clk = 1'b0;
    reg         nrst, setpoint_stb, enc_load;
    reg  [15:0] ctrl_word;
    reg  [31:0] enc_inc, pos_int, vel_in, pe;
    reg  [64:0] x;
    reg  [7:0]  codes [0:4];
    wire        od_req, od_wr, od_done, od_abort, enc_abort, pos_valid;
    wire        emcy_stb, limit_rescale, limit_neg;
    wire [15:0] od_index, err_reg, emcy_code;
    wire [7:0]  od_sub, mode_active;
    wire [31:0] od_wdata, od_rdata, od_abort_code, pos_act, vel_out;
    integer     n_mismatch = 0, tests_run = 0, seed = 32'he6b0, i;
    always #4 sys_clk = ~sys_clk;
    dmss_host host (.clk(sys_clk), .od_req(od_req), .od_wr(od_wr),
        .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata));
    dmss_top #(.ENC_INC_DEFAULT(ENC), .FEED_DEFAULT(ENC)) dut (
        .SYS_CLK(sys_clk), .NRST(nrst), .OD_REQ(od_req), .OD_WR(od_wr),
        .OD_INDEX(od_index), .OD_SUB(od_sub), .OD_WDATA(od_wdata),
        .OD_DONE(od_done), .OD_RDATA(od_rdata), .OD_ABORT(od_abort),
        .OD_ABORT_CODE(od_abort_code), .CTRL_WORD(ctrl_word),
        .SETPOINT_STB(setpoint_stb), .ENC_LOAD(enc_load),
        .ENC_INCREMENTS(enc_inc), .ENC_ABORT(enc_abort),
        .POS_INTERNAL(pos_int), .POS_ACTUAL(pos_act), .POS_VALID(pos_valid),
        .VEL_IN(vel_in), .VEL_OUT(vel_out), .MODE_ACTIVE(mode_active),
        .ERR_REG(err_reg), .EMCY_STB(emcy_stb), .EMCY_CODE(emcy_code),
        .LIMIT_RESCALE(limit_rescale), .LIMIT_NEG(limit_neg)
    );
    // Each answer against the oldest note
    always @(negedge sys_clk) begin
        if (od_done === 1'b1) begin
            x = host.exp_q.pop_front();
            `CHK(od_abort, x[64])
            `CHK(od_rdata, x[31:0])
            if (x[64]) `CHK(od_abort_code, x[63:32])
        end
    end
    task rd(input [15:0] i, input [7:0] s, input [31:0] r);
        host.access(1'b0, i, s, 32'h0, 1'b0, 32'h0, r);
    endtask
    task wr(input [15:0] i, input [7:0] s, input [31:0] d, input [31:0] c);
        host.access(1'b1, i, s, d, c != 32'h0, c, 32'h0);
    endtask
    // Expected user position, truncated toward zero
    function [31:0] upos(input [31:0] p, input longint nm, input longint dv);
        upos = (longint'($signed(p)) * dv) / nm;
    endfunction
    // Wait for a conversion, or an emergency, after a new position
    task conv(input [31:0] p, input bit on_emcy);
        integer k;
        @(negedge sys_clk);
        pos_int = p;
        k = 0;
        repeat (on_emcy ? 1 : 2) begin
            @(negedge sys_clk);
            while ((on_emcy ? emcy_stb : pos_valid) !== 1'b1 && k < 400) begin
                @(negedge sys_clk);
                k++;
            end
        end
        `CHK(k < 400, 1'b1)
    endtask
    task enc(input [31:0] n, input bit ab);
        @(negedge sys_clk);
        enc_inc = n;
        enc_load = 1'b1;
        @(negedge sys_clk);
        enc_load = 1'b0;
        enc_inc = ~n;
        `CHK(enc_abort, ab)
        `CHK(limit_rescale, !ab)
    endtask
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #400000;
        n_mismatch++;
        give_verdict;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        setpoint_stb = 1'b0;
        enc_load = 1'b0;
        pe = $random(seed);
        ctrl_word = pe[15:0] & 16'hffef;
        enc_inc = 32'h0;
        pos_int = 32'h0;
        vel_in = 32'h0;
        codes = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h08};
        repeat (12) @(negedge sys_clk);
        nrst = 1'b1;
        rd(`DMSS_IDX_MODE_SEL, 8'h00, 32'h1);
        rd(`DMSS_IDX_MODE_DISP, 8'h00, 32'h1);
        rd(`DMSS_IDX_POLARITY, 8'h00, 32'h0);
        rd(`DMSS_IDX_ENC_RES, 8'h00, 32'h2);
        rd(`DMSS_IDX_ENC_RES, 8'h01, ENC);
        rd(`DMSS_IDX_ENC_RES, 8'h02, 32'h1);
        rd(`DMSS_IDX_GEAR, 8'h01, 32'h1);
        rd(`DMSS_IDX_GEAR, 8'h02, 32'h1);
        rd(`DMSS_IDX_FEED, 8'h00, 32'h2);
        rd(`DMSS_IDX_FEED, 8'h01, ENC);
        rd(`DMSS_IDX_FEED, 8'h02, 32'h1);
        rd(`DMSS_IDX_FACTOR, 8'h01, 32'h1);
        rd(`DMSS_IDX_FACTOR, 8'h02, 32'h1);
        wr(`DMSS_IDX_MODE_DISP, 8'h00, 32'h3, `DMSS_ABT_RO);
        wr(`DMSS_IDX_ENC_RES, 8'h01, 32'h5, `DMSS_ABT_RO);
        wr(`DMSS_IDX_FACTOR, 8'h01, 32'h5, `DMSS_ABT_RO);
        wr(`DMSS_IDX_GEAR, 8'h00, 32'h3, `DMSS_ABT_RO);
        wr(`DMSS_IDX_GEAR, 8'h03, 32'h1, `DMSS_ABT_NOSUB);
        wr(16'h6000, 8'h00, 32'h1, `DMSS_ABT_NOOBJ);
        pe = $random(seed);
        conv(pe, 1'b0);
        `CHK(pos_act, pe)
        // Every mode code, with its start condition
        for (i = 0; i < 5; i++) begin
            wr(`DMSS_IDX_MODE_SEL, 8'h00, {24'h0, codes[i]}, 32'h0);
            repeat (3) @(negedge sys_clk);
            if (i >= 1 && i <= 3) begin
                `CHK(mode_active, codes[i - 1])
                setpoint_stb = (i != 3);
                ctrl_word[4] = (i == 3);
                @(negedge sys_clk);
                setpoint_stb = 1'b0;
                ctrl_word[4] = 1'b0;
                repeat (2) @(negedge sys_clk);
            end
            `CHK(mode_active, codes[i])
            rd(`DMSS_IDX_MODE_DISP, 8'h00, {24'h0, codes[i]});
        end
        wr(`DMSS_IDX_MODE_SEL, 8'h00, 32'h102, `DMSS_ABT_RANGE);
        rd(`DMSS_IDX_MODE_SEL, 8'h00, 32'h8);
        // Gear change, factor and truncation
        wr(`DMSS_IDX_GEAR, 8'h01, 32'h2, 32'h0);
        @(negedge sys_clk);
        `CHK(limit_rescale, 1'b1)
        rd(`DMSS_IDX_FACTOR, 8'h01, ENC * 2);
        rd(`DMSS_IDX_FACTOR, 8'h02, ENC);
        pe = $random(seed);
        pe = -({12'h0, pe[19:0]} | 32'h1);
        conv(pe, 1'b0);
        `CHK(pos_act, upos(pe, ENC * 2, ENC))
        wr(`DMSS_IDX_GEAR, 8'h01, 32'hf4240, `DMSS_ABT_OVF);
        wr(`DMSS_IDX_GEAR, 8'h01, 32'h0, `DMSS_ABT_OVF);
        rd(`DMSS_IDX_FACTOR, 8'h01, ENC * 2);
        // Direction polarity for position, then speed
        wr(`DMSS_IDX_POLARITY, 8'h00, 32'h80, 32'h0);
        @(negedge sys_clk);
        `CHK(limit_rescale, 1'b1)
        pe = $random(seed);
        conv(pe, 1'b0);
        `CHK(pos_act, -upos(pe, ENC * 2, ENC))
        `CHK(limit_neg, 1'b1)
        wr(`DMSS_IDX_POLARITY, 8'h00, 32'h40, 32'h0);
        @(negedge sys_clk);
        vel_in = $random(seed);
        pos_int = 32'h0;
        repeat (2) @(negedge sys_clk);
        `CHK(vel_out, -vel_in)
        `CHK(limit_neg, 1'b0)
        // Encoder changes, refused and taken
        enc(32'h59682f00, 1'b1);
        enc(32'h800, 1'b0);
        rd(`DMSS_IDX_ENC_RES, 8'h01, 32'h800);
        rd(`DMSS_IDX_FACTOR, 8'h01, 32'h1000);
        // Conversion overflow raised and cleared
        wr(`DMSS_IDX_GEAR, 8'h01, 32'h1, 32'h0);
        wr(`DMSS_IDX_FEED, 8'h01, 32'hffff0000, 32'h0);
        conv(32'h100000, 1'b1);
        `CHK(emcy_code, `DMSS_EMCY_OVF)
        `CHK(err_reg[11], 1'b1)
        conv(32'h1, 1'b1);
        `CHK(emcy_code, `DMSS_EMCY_CLR)
        `CHK(err_reg[11], 1'b0)
        `CHK(pos_act, upos(32'h1, 32'h800, 32'hffff0000))
        give_verdict;
    end
endmodule
